// file: dv/rotate_set_sleep_exec_tb_top.sv
// self-checking bench for the rotate, set all ones and sleep block
`timescale 1ns/1ps
`default_nettype none
module rotate_set_sleep_exec_tb_top;
  logic core_clk, rst, ce, psel, penable, pwrite, watchdog_wake;
  logic [7:0] paddr; // apb byte address
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, file_we, indexed_mode, watchdog_clear;
  logic osc_stop, other_insn;
  logic [11:0] file_addr; // file write address
  logic [7:0] file_wdata; // file write data
  int n_errors, checks_done;
  int we_cnt, clr_cnt; // pulse counts seen by the monitor
  logic [11:0] last_addr;
  logic [7:0] last_data;
  logic last_idx;

  rotate_set_sleep_exec rotate_set_sleep_exec_inst (
    .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_wake(watchdog_wake),
    .file_we(file_we),
    .file_addr(file_addr), .file_wdata(file_wdata),
    .indexed_mode(indexed_mode),
    .watchdog_clear(watchdog_clear),
    .osc_stop(osc_stop), .other_insn(other_insn)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pulses are counted at the falling edge, clear of update races
  always @(negedge core_clk) begin
    if (file_we === 1'b1) begin
      we_cnt++;
      last_addr = file_addr;
      last_data = file_wdata;
      last_idx = indexed_mode;
    end
    if (watchdog_clear === 1'b1) begin
      clr_cnt++;
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a used-up wait bound counts as a mismatch and closes the run
  task automatic give_up();
    n_errors++;
    end_sim();
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; answer taken at the rising edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // values read here are those sampled at this rising edge
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) give_up();
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // start an instruction and poll until the block is idle again
  task automatic run_insn(input logic [15:0] w);
    logic [31:0] s;
    int n;
    n = 0;
    wr(rsse_pkg::ADDR_INSN, {16'h0000, w});
    do begin
      rd(rsse_pkg::ADDR_STATUS, s);
      n++;
      if (n > 30) give_up();
    end while (s[rsse_pkg::ST_BUSY] !== 1'b0);
  endtask

  // run one word, then judge the file write and the status byte
  task automatic do_insn(input logic [15:0] w, input int we,
                         input logic [7:0] d, input logic [11:0] a,
                         input logic idx, input logic [7:0] st);
    logic [31:0] s;
    int c;
    c = we_cnt;
    run_insn(w);
    chk("file write count", we, we_cnt - c);
    if (we == 1) begin
      chk("file data", {24'h0, d}, {24'h0, last_data});
      chk("file addr", {20'h0, a}, {20'h0, last_addr});
      chk("indexed", {31'h0, idx}, {31'h0, last_idx});
    end
    rd(rsse_pkg::ADDR_STATUS, s);
    chk("status", {24'h0, st}, {24'h0, s[7:0]});
  endtask

  // through-carry rotate to file and to accumulator
  task automatic t_rrc();
    logic [31:0] w;
    wr(rsse_pkg::ADDR_CTRL, 32'h300);
    wr(rsse_pkg::ADDR_FILE_IN, 32'h01);
    wr(rsse_pkg::ADDR_STATUS, 32'h0);
    do_insn({rsse_pkg::OPC_RRC, 2'b11, 8'h20}, 1, 8'h00, 12'h320, 1'b0,
            8'h1b);
    wr(rsse_pkg::ADDR_STATUS, 32'h1);
    wr(rsse_pkg::ADDR_FILE_IN, 32'h02);
    do_insn({rsse_pkg::OPC_RRC, 2'b11, 8'h21}, 1, 8'h81, 12'h321, 1'b0,
            8'h1c);
    wr(rsse_pkg::ADDR_FILE_IN, 32'h80);
    do_insn({rsse_pkg::OPC_RRC, 2'b01, 8'h22}, 0, 8'h00, 12'h0, 1'b0,
            8'h18);
    rd(rsse_pkg::ADDR_WREG, w);
    chk("wreg", 32'h40, {24'h0, w[7:0]});
    rd(rsse_pkg::ADDR_RESULT, w);
    chk("result val", 32'h40, {24'h0, w[7:0]});
    chk("dest w", 32'h1, {31'h0, w[rsse_pkg::RES_DESTW_BIT]});
  endtask

  // plain rotate keeps carry; access bank split at 60h
  task automatic t_rrn();
    logic [31:0] w;
    wr(rsse_pkg::ADDR_STATUS, 32'h1);
    wr(rsse_pkg::ADDR_FILE_IN, 32'hd7);
    do_insn({rsse_pkg::OPC_RRN, 2'b10, 8'h70}, 1, 8'heb, 12'hf70, 1'b0,
            8'h1d);
    wr(rsse_pkg::ADDR_FILE_IN, 32'h01);
    do_insn({rsse_pkg::OPC_RRN, 2'b10, 8'h10}, 1, 8'h80, 12'h010, 1'b0,
            8'h1d);
    wr(rsse_pkg::ADDR_STATUS, 32'h0);
    wr(rsse_pkg::ADDR_FILE_IN, 32'hd7);
    do_insn({rsse_pkg::OPC_RRN, 2'b01, 8'h10}, 0, 8'h00, 12'h0, 1'b0,
            8'h1c);
    rd(rsse_pkg::ADDR_WREG, w);
    chk("wreg", 32'heb, {24'h0, w[7:0]});
  endtask

  // set all ones with indexed offset at its boundary, flags kept
  task automatic t_set();
    wr(rsse_pkg::ADDR_CTRL, 32'h501);
    wr(rsse_pkg::ADDR_IDX_BASE, 32'h100);
    wr(rsse_pkg::ADDR_STATUS, 32'h5);
    do_insn({rsse_pkg::OPC_SET, 1'b0, 8'h5f}, 1, 8'hff, 12'h15f, 1'b1,
            8'h1d);
    do_insn({rsse_pkg::OPC_SET, 1'b0, 8'h60}, 1, 8'hff, 12'hf60, 1'b0,
            8'h1d);
    do_insn({rsse_pkg::OPC_SET, 1'b1, 8'h5f}, 1, 8'hff, 12'h55f, 1'b0,
            8'h1d);
  endtask

  // clock enable low freezes the sequencer in mid-instruction
  task automatic t_freeze();
    int c;
    c = we_cnt;
    wr(rsse_pkg::ADDR_INSN, {16'h0000, rsse_pkg::OPC_SET, 9'h010});
    ce <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("frozen write", c, we_cnt);
    ce <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("thawed write", c + 1, we_cnt);
  endtask

  // sleep, refused word while asleep, watchdog wake, sleep again
  task automatic t_sleep();
    logic [31:0] s;
    int c;
    int k;
    int n;
    for (k = 0; k < 2; k++) begin
      c = clr_cnt;
      run_insn(rsse_pkg::OPC_SLEEP);
      chk("watchdog clear", c + 1, clr_cnt);
      chk("osc stop", 32'h1, {31'h0, osc_stop});
      rd(rsse_pkg::ADDR_STATUS, s);
      chk("sleep bits", 32'h5, {29'h0, s[5:3]});
      c = we_cnt;
      wr(rsse_pkg::ADDR_INSN, {16'h0000, rsse_pkg::OPC_SET, 9'h0});
      repeat (6) @(posedge core_clk);
      chk("asleep write", c, we_cnt);
      watchdog_wake <= 1'b1;
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
        if (n > 20) give_up();
      end while (osc_stop !== 1'b0);
      rd(rsse_pkg::ADDR_STATUS, s);
      chk("wake bits", 32'h0, {29'h0, s[5:3]});
      @(posedge core_clk);
      watchdog_wake <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask

  // foreign words and an unmapped address
  task automatic t_other();
    logic [15:0] ws [4];
    logic [31:0] r;
    logic e;
    int c;
    int k;
    ws = '{16'h0002, 16'h0004, 16'h3800, 16'h6a00};
    for (k = 0; k < 4; k++) begin
      c = we_cnt;
      run_insn(ws[k]);
      chk("other insn", 32'h1, {31'h0, other_insn});
      chk("no write", c, we_cnt);
    end
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    watchdog_wake = 1'b0;
    n_errors = 0;
    checks_done = 0;
    we_cnt = 0;
    clr_cnt = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_rrc();
    t_rrn();
    t_set();
    t_freeze();
    t_sleep();
    t_other();
    end_sim();
  end
endmodule
`default_nettype wire

// file: hw/rot_unit.sv
// one-place right rotate, with or without the carry in the loop
`timescale 1ns/1ps
`default_nettype none
module rot_unit (
  input wire logic [7:0] din,
  input wire logic cin,
  input wire logic thru,
  output logic [7:0] dout,
  output logic cout
);
  // top bit takes old carry when rotating through it, else bit 0 wraps
  assign dout = {(thru ? cin : din[0]), din[7:1]};
  // carry out is old bit 0 only in the through-carry form
  assign cout = thru ? din[0] : cin;
endmodule
`default_nettype wire

// file: hw/rotate_set_sleep_exec.sv
// execution block for rotate right, set all ones and sleep
// Behaviour
// - through-carry rotate: carry into bit7, bit0 out
// - plain rotate wraps bit 0 into bit 7
// - plain rotate decoded from top bits 010000
// - plain rotate sets N and Z, keeps carry
// - d=0 writes accumulator, d=1 writes file
// - a=0 access bank, a=1 bank select register
// - a=0, extended set, f<=5Fh: indexed offset
// - set instruction writes FFh, flags untouched
// - sleep decoded from fixed word 0003h
// - sleep clears power-down status bit
// - sleep sets time-out status bit
// - sleep clears watchdog count and postscaler
// - last phase enters sleep, oscillator stops
// - watchdog wake-up clears time-out bit
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rotate_set_sleep_exec (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_wake,
  output logic file_we,
  output logic [11:0] file_addr,
  output logic [7:0] file_wdata,
  output logic indexed_mode,
  output logic watchdog_clear,
  output logic osc_stop,
  output logic other_insn
);
  rsse_pkg::phase_e state; // instruction cycle phase
  rsse_pkg::op_e op; // operation latched at decode
  logic ext_en; // extended instruction set enable
  logic [3:0] bank_select_register; // bank for a=1 accesses
  logic [11:0] idx_base; // base for indexed offset mode
  logic [15:0] insn; // instruction word under execution
  logic [7:0] file_in; // value the file register reads back
  logic [7:0] wreg; // working accumulator
  logic c; // carry flag
  logic z; // zero flag
  logic n; // negative flag
  logic timeout_status_bit; // active-low time-out flag
  logic powerdown_status_bit; // active-low power-down flag
  logic sleeping; // core halted in sleep
  logic [7:0] operand; // byte read in phase two
  logic [7:0] res_val; // processed result
  logic res_c; // processed carry
  logic res_dest_w; // last result went to accumulator
  logic rd_rdy; // read data prepared in setup cycle
  logic rd_bad; // setup cycle hit an unmapped address
  logic [31:0] rd_mux; // read data selection
  logic addr_hit; // address is mapped
  logic wake_lvl; // filtered watchdog wake level

  // bus phase decode
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire wr_acc = acc && pwrite && !rd_bad;
  wire wr_ctrl = wr_acc && (paddr == rsse_pkg::ADDR_CTRL);
  wire wr_insn = wr_acc && (paddr == rsse_pkg::ADDR_INSN);
  wire wr_file = wr_acc && (paddr == rsse_pkg::ADDR_FILE_IN);
  wire wr_wreg = wr_acc && (paddr == rsse_pkg::ADDR_WREG);
  wire wr_stat = wr_acc && (paddr == rsse_pkg::ADDR_STATUS);
  wire wr_idx = wr_acc && (paddr == rsse_pkg::ADDR_IDX_BASE);

  // opcode decode from the latched word
  wire is_rrc = insn[15:10] == rsse_pkg::OPC_RRC;
  wire is_rrn = insn[15:10] == rsse_pkg::OPC_RRN;
  wire is_set = insn[15:9] == rsse_pkg::OPC_SET;
  wire is_sleep = insn == rsse_pkg::OPC_SLEEP;
  wire is_ours = is_rrc || is_rrn || is_set || is_sleep;
  wire d_bit = insn[rsse_pkg::BIT_D];
  wire a_bit = insn[rsse_pkg::BIT_A];
  wire [7:0] f_addr = insn[7:0];

  // a new word is only taken while idle and awake
  wire start = wr_insn && (state == rsse_pkg::ph_idle) && !sleeping;

  // operand addressing: bank select, access bank or indexed
  wire low_half = f_addr < rsse_pkg::ACC_SPLIT;
  wire [3:0] acc_bank = low_half ? rsse_pkg::ACC_LOW_BANK
                                 : rsse_pkg::ACC_HIGH_BANK;
  wire [11:0] bank_addr = a_bit ? {bank_select_register, f_addr}
                                : {acc_bank, f_addr};
  wire use_idx = !a_bit && ext_en
                 && (f_addr <= rsse_pkg::IDX_LIMIT);
  wire [12:0] idx_sum = {1'b0, idx_base} + {5'h00, f_addr};
  wire [11:0] eff_addr = use_idx ? idx_sum[11:0] : bank_addr;

  // rotate datapath; carry enters the loop only for rrc
  wire [7:0] rot_out;
  wire rot_c;
  rot_unit rot_unit_inst (
    .din(operand),
    .cin(c),
    .thru(op == rsse_pkg::op_rrc),
    .dout(rot_out),
    .cout(rot_c)
  );

  // watchdog wake pin comes from another domain
  sync3 sync3_inst (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async_in(watchdog_wake),
    .level(wake_lvl)
  );

  wire wake = sleeping && wake_lvl;
  wire rot_wr = (state == rsse_pkg::ph_write)
                && ((op == rsse_pkg::op_rrc) || (op == rsse_pkg::op_rrn));
  wire sleep_go = (state == rsse_pkg::ph_process)
                  && (op == rsse_pkg::op_sleep);

  // read data selection, unmapped addresses flagged
  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_hit = 1'b1;
    if (paddr == rsse_pkg::ADDR_CTRL) begin
      rd_mux[rsse_pkg::CTRL_EXT_BIT] = ext_en;
      rd_mux[rsse_pkg::CTRL_BANK_LSB +: 4] = bank_select_register;
    end else if (paddr == rsse_pkg::ADDR_INSN) begin
      rd_mux[15:0] = insn;
    end else if (paddr == rsse_pkg::ADDR_FILE_IN) begin
      rd_mux[7:0] = file_in;
    end else if (paddr == rsse_pkg::ADDR_WREG) begin
      rd_mux[7:0] = wreg;
    end else if (paddr == rsse_pkg::ADDR_STATUS) begin
      rd_mux[rsse_pkg::ST_C] = c;
      rd_mux[rsse_pkg::ST_Z] = z;
      rd_mux[rsse_pkg::ST_N] = n;
      rd_mux[rsse_pkg::ST_TIMEOUT] = timeout_status_bit;
      rd_mux[rsse_pkg::ST_POWERDOWN] = powerdown_status_bit;
      rd_mux[rsse_pkg::ST_SLEEP] = sleeping;
      rd_mux[rsse_pkg::ST_BUSY] = state != rsse_pkg::ph_idle;
      rd_mux[rsse_pkg::ST_OTHER] = other_insn;
    end else if (paddr == rsse_pkg::ADDR_RESULT) begin
      rd_mux[7:0] = res_val;
      rd_mux[rsse_pkg::RES_ADDR_LSB +: 12] = file_addr;
      rd_mux[rsse_pkg::RES_DESTW_BIT] = res_dest_w;
      rd_mux[rsse_pkg::RES_IDX_BIT] = indexed_mode;
    end else if (paddr == rsse_pkg::ADDR_IDX_BASE) begin
      rd_mux[11:0] = idx_base;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // ready only once data was captured, so prdata is a flop
  // held low while frozen, so no write is reported that never lands
  assign pready = penable && rd_rdy && ce;
  assign pslverr = pready && rd_bad;

  // read data captured in the setup cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      rd_rdy <= 1'b0;
      rd_bad <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata <= rd_mux;
        rd_bad <= !addr_hit;
        rd_rdy <= 1'b1;
      end else if (acc) begin
        rd_rdy <= 1'b0;
      end
    end
  end

  // software configuration registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_en <= 1'b0;
      bank_select_register <= rsse_pkg::BANK_SEL_RESET;
      idx_base <= rsse_pkg::IDX_BASE_RESET;
      file_in <= 8'h00;
    end else if (ce) begin
      if (wr_ctrl) begin
        ext_en <= pwdata[rsse_pkg::CTRL_EXT_BIT];
        bank_select_register <= pwdata[rsse_pkg::CTRL_BANK_LSB +: 4];
      end
      if (wr_idx) begin
        idx_base <= pwdata[11:0];
      end
      if (wr_file) begin
        file_in <= pwdata[7:0];
      end
    end
  end

  // instruction word: writes while busy are ignored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      insn <= 16'h0000;
    end else if (ce && start) begin
      insn <= pwdata[15:0];
    end
  end

  // four-phase sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= rsse_pkg::ph_idle;
      op <= rsse_pkg::op_none;
      other_insn <= 1'b0;
    end else if (ce) begin
      case (state)
        rsse_pkg::ph_idle: begin
          if (start) begin
            state <= rsse_pkg::ph_decode;
            other_insn <= 1'b0;
          end
        end
        rsse_pkg::ph_decode: begin
          // foreign words belong to other decode logic
          if (!is_ours) begin
            state <= rsse_pkg::ph_idle;
            other_insn <= 1'b1;
            op <= rsse_pkg::op_none;
          end else begin
            state <= rsse_pkg::ph_read;
            if (is_rrc) begin
              op <= rsse_pkg::op_rrc;
            end else if (is_rrn) begin
              op <= rsse_pkg::op_rrn;
            end else if (is_set) begin
              op <= rsse_pkg::op_set;
            end else begin
              op <= rsse_pkg::op_sleep;
            end
          end
        end
        rsse_pkg::ph_read: state <= rsse_pkg::ph_process;
        rsse_pkg::ph_process: state <= rsse_pkg::ph_write;
        rsse_pkg::ph_write: state <= rsse_pkg::ph_idle;
        default: state <= rsse_pkg::ph_idle;
      endcase
    end
  end

  // operand read and processing; sleep reads nothing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      operand <= 8'h00;
      res_val <= 8'h00;
      res_c <= 1'b0;
    end else if (ce) begin
      if (state == rsse_pkg::ph_read && op != rsse_pkg::op_sleep) begin
        operand <= file_in;
      end
      if (state == rsse_pkg::ph_process) begin
        if (op == rsse_pkg::op_set) begin
          res_val <= rsse_pkg::ALL_ONES;
        end else if (op != rsse_pkg::op_sleep) begin
          res_val <= rot_out;
          res_c <= rot_c;
        end
      end
    end
  end

  // destination write in the last phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      file_we <= 1'b0;
      file_addr <= 12'h000;
      file_wdata <= 8'h00;
      indexed_mode <= 1'b0;
      res_dest_w <= 1'b0;
    end else if (ce) begin
      file_we <= 1'b0;
      if (state == rsse_pkg::ph_write && op != rsse_pkg::op_sleep) begin
        // set always targets the file; rotates follow d
        res_dest_w <= rot_wr && !d_bit;
        file_we <= !(rot_wr && !d_bit);
        file_addr <= eff_addr;
        file_wdata <= res_val;
        indexed_mode <= use_idx;
      end
    end
  end

  // accumulator: a result written here beats a bus write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wreg <= 8'h00;
    end else if (ce) begin
      if (rot_wr && !d_bit) begin
        wreg <= res_val;
      end else if (wr_wreg) begin
        wreg <= pwdata[7:0];
      end
    end
  end

  // arithmetic flags: hardware update wins over bus write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      c <= 1'b0;
      z <= 1'b0;
      n <= 1'b0;
    end else if (ce) begin
      if (rot_wr) begin
        n <= res_val[7];
        z <= res_val == 8'h00;
        // plain rotate hands the old carry straight back
        c <= res_c;
      end else if (wr_stat) begin
        c <= pwdata[rsse_pkg::ST_C];
        z <= pwdata[rsse_pkg::ST_Z];
        n <= pwdata[rsse_pkg::ST_N];
      end
    end
  end

  // sleep entry, wake-up and the two status bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timeout_status_bit <= rsse_pkg::TIMEOUT_RESET;
      powerdown_status_bit <= rsse_pkg::POWERDOWN_RESET;
      sleeping <= 1'b0;
      osc_stop <= 1'b0;
      watchdog_clear <= 1'b0;
    end else if (ce) begin
      watchdog_clear <= sleep_go;
      if (sleep_go) begin
        powerdown_status_bit <= 1'b0;
        timeout_status_bit <= 1'b1;
      end
      if (state == rsse_pkg::ph_write && op == rsse_pkg::op_sleep) begin
        sleeping <= 1'b1;
        osc_stop <= 1'b1;
      end else if (wake) begin
        // a wake level already high stops sleep one cycle later
        sleeping <= 1'b0;
        osc_stop <= 1'b0;
        timeout_status_bit <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_sleep_proc;
    ce && sleep_go;
  endsequence
  sequence s_sleep_full;
    s_sleep_proc ##1 ce;
  endsequence

  chk_sleep_pd: assert property (
    s_sleep_proc |=> !powerdown_status_bit)
    else $error("sleep left power-down bit set");
  chk_sleep_to: assert property (
    s_sleep_proc |=> timeout_status_bit)
    else $error("sleep did not set time-out bit");
  chk_watchdog_clear: assert property (
    s_sleep_proc |=> watchdog_clear ##1 (!watchdog_clear || !$past(ce)))
    else $error("watchdog clear not one pulse");
  chk_sleep_entry: assert property (
    s_sleep_full |=> sleeping && osc_stop && !file_we)
    else $error("sleep not entered in last phase");
  chk_wake_to: assert property (
    ce && sleeping && wake_lvl |=> !timeout_status_bit && !sleeping)
    else $error("watchdog wake did not clear time-out");
  chk_set_ones: assert property (
    ce && state == rsse_pkg::ph_write && op == rsse_pkg::op_set
    |=> file_we && file_wdata == 8'hff && $stable({c, z, n}))
    else $error("set did not write all ones cleanly");
  chk_rrn_carry: assert property (
    ce && rot_wr && op == rsse_pkg::op_rrn |=> c == $past(c))
    else $error("plain rotate changed carry");
  chk_rrc_carry: assert property (
    ce && rot_wr && op == rsse_pkg::op_rrc
    |=> c == $past(operand[0]) && n == $past(c))
    else $error("through-carry rotate carry wrong");
  chk_dest_acc: assert property (
    ce && rot_wr && !d_bit |=> wreg == $past(res_val) && !file_we)
    else $error("d=0 result not in accumulator");
  chk_foreign_op: assert property (
    ce && state == rsse_pkg::ph_decode && !is_ours
    |=> state == rsse_pkg::ph_idle && other_insn && !file_we)
    else $error("foreign opcode activated block");
  chk_four_phase: assert property (
    ce && state == rsse_pkg::ph_decode && is_ours ##1 ce ##1 ce
    |=> state == rsse_pkg::ph_write)
    else $error("instruction not in four phases");
endmodule
`default_nettype wire

// file: hw/rsse_pkg.sv
// constants for the rotate, set-all-ones and sleep execution block
package rsse_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INSN = 8'h04;
  localparam logic [7:0] ADDR_FILE_IN = 8'h08;
  localparam logic [7:0] ADDR_WREG = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_RESULT = 8'h14;
  localparam logic [7:0] ADDR_IDX_BASE = 8'h18;
  // control register fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_BANK_LSB = 8;
  // status register fields
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_POWERDOWN = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_OTHER = 7;
  // result register fields
  localparam int RES_ADDR_LSB = 8;
  localparam int RES_DESTW_BIT = 20;
  localparam int RES_IDX_BIT = 21;
  // opcode fields and encodings
  localparam int BIT_D = 9;
  localparam int BIT_A = 8;
  localparam logic [5:0] OPC_RRC = 6'h0c;
  localparam logic [5:0] OPC_RRN = 6'h10;
  localparam logic [6:0] OPC_SET = 7'h34;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;
  // bank and addressing constants
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // reset values
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;
  localparam logic [3:0] BANK_SEL_RESET = 4'h0;
  localparam logic [11:0] IDX_BASE_RESET = 12'h000;
  // instruction cycle phases
  typedef enum logic [2:0] {
    ph_idle, ph_decode, ph_read, ph_process, ph_write
  } phase_e;
  // decoded operation
  typedef enum logic [2:0] {
    op_none, op_rrc, op_rrn, op_set, op_sleep
  } op_e;
endpackage

// file: hw/sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic level
);
  logic s1; // metastable stage, read only by s2
  logic s2;
  logic s3;

  // shift chain; level moves only once s2 and s3 agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire
